// >>> core/ulsi_pkg.sv
package ulsi_pkg;
   // Register word offsets (byte addresses, one aligned word each)
   localparam logic [3:0] ULSI_OFF_DATA = 4'h0;
   localparam logic [3:0] ULSI_OFF_IER = 4'h4;
   localparam logic [3:0] ULSI_OFF_ISR = 4'h8;
   localparam logic [3:0] ULSI_OFF_LSR = 4'hC;
   localparam logic [3:0] ULSI_OFF_CFG = 4'h0;
   // Line status bit positions
   localparam int ULSI_LS_DR = 0;
   localparam int ULSI_LS_OE = 1;
   localparam int ULSI_LS_PE = 2;
   localparam int ULSI_LS_FE = 3;
   localparam int ULSI_LS_BI = 4;
   localparam int ULSI_LS_TE = 5;
   localparam int ULSI_LS_TI = 6;
   localparam int ULSI_LS_DE = 7;
   // Enable bit positions
   localparam int ULSI_IE_RDA = 0;
   localparam int ULSI_IE_THE = 1;
   localparam int ULSI_IE_RLS = 2;
   localparam int ULSI_IE_MS = 3;
   localparam int ULSI_IE_SLP = 4;
   localparam int ULSI_IE_SPC = 5;
   localparam int ULSI_IE_RTS = 6;
   localparam int ULSI_IE_CTS = 7;
   // Config register bit positions (config word at offset 0x10)
   localparam logic [4:0] ULSI_ADR_CFG = 5'h10;
   localparam int ULSI_CF_NINE = 0;
   localparam int ULSI_CF_ENH = 1;
   localparam int ULSI_CF_BYTE = 2;
   localparam int ULSI_CF_M750 = 3;
   localparam int ULSI_CF_F128 = 4;
   localparam int ULSI_CF_OUT2 = 5;
   localparam int ULSI_CF_M950 = 6;
   localparam int ULSI_CF_PAR = 7;
   localparam logic [7:0] ULSI_RST_IER = 8'h00;
   localparam logic [7:0] ULSI_RST_CFG = 8'h00;
   // Identification codes
   localparam logic [5:0] ULSI_ID_NONE = 6'h01;
   localparam logic [5:0] ULSI_ID_RLS = 6'h06;
   localparam logic [5:0] ULSI_ID_RDA = 6'h04;
   localparam logic [5:0] ULSI_ID_TMO = 6'h0C;
   localparam logic [5:0] ULSI_ID_THE = 6'h02;
   localparam logic [5:0] ULSI_ID_MS = 6'h00;
   localparam logic [5:0] ULSI_ID_SPC = 6'h10;
   localparam logic [5:0] ULSI_ID_CR = 6'h20;
   // Receive FIFO
   localparam int ULSI_FIFO_DEPTH = 16;
   localparam int ULSI_FIFO_AW = 4;
   localparam int ULSI_FIFO_W = 12;
   // Serial timing
   localparam int ULSI_CLK_HZ = 50_000_000;
   localparam int ULSI_BAUD = 115_200;
   localparam int ULSI_BIT_CYC = ULSI_CLK_HZ / ULSI_BAUD;
   localparam int ULSI_TMO_CHARS = 4;
   localparam int ULSI_CHAR_BITS = 10;
   localparam int ULSI_TMO_CYC = ULSI_TMO_CHARS * ULSI_CHAR_BITS * ULSI_BIT_CYC;
   localparam int ULSI_CNT_W = 16;
   localparam int ULSI_TMO_W = 16;
   localparam logic [ULSI_CNT_W-1:0] ULSI_BIT_LAST = ULSI_CNT_W'(ULSI_BIT_CYC - 1);
   localparam logic [ULSI_CNT_W-1:0] ULSI_HALF_LAST = ULSI_CNT_W'(ULSI_BIT_CYC / 2 - 1);
   localparam logic [3:0] ULSI_DATA_LAST = 4'h8;
   typedef enum logic [2:0] {
      ULSI_RX_IDLE = 3'b000,
      ULSI_RX_START = 3'b001,
      ULSI_RX_DATA = 3'b011,
      ULSI_RX_STOP = 3'b010,
      ULSI_RX_BRK = 3'b110
   } ulsi_rx_state_t;
endpackage

// >>> core/ulsi_rx.sv
`timescale 1ns/1ps
module ulsi_rx
   import ulsi_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic serial_in_i,
   input wire logic nine_i,
   input wire logic par_en_i,
   output logic done_o,
   output logic [8:0] data_o,
   output logic par_err_o,
   output logic frm_err_o,
   output logic brk_o
);
   ulsi_rx_state_t st_q;
   logic [ULSI_CNT_W-1:0] cnt_q;
   logic [3:0] bit_q;
   logic [8:0] sh_q;
   logic low_q;
   wire tick = (cnt_q == 0);
   wire [3:0] nbits = nine_i ? ULSI_DATA_LAST + 4'h1 : (par_en_i ? ULSI_DATA_LAST + 4'h1
                                                                   : ULSI_DATA_LAST);

   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      if (rst_i) begin
         st_q <= ULSI_RX_IDLE;
         cnt_q <= '0;
         bit_q <= '0;
         sh_q <= '0;
         low_q <= 1'b0;
         data_o <= '0;
         par_err_o <= 1'b0;
         frm_err_o <= 1'b0;
         brk_o <= 1'b0;
      end else begin
         if (!tick)
            cnt_q <= cnt_q - 1'b1;
         unique case (st_q)
            ULSI_RX_IDLE: if (!serial_in_i) begin
               st_q <= ULSI_RX_START;
               cnt_q <= ULSI_HALF_LAST;
            end
            ULSI_RX_START: if (tick) begin
               st_q <= serial_in_i ? ULSI_RX_IDLE : ULSI_RX_DATA;
               cnt_q <= ULSI_BIT_LAST;
               bit_q <= '0;
               low_q <= 1'b1;
            end
            ULSI_RX_DATA: if (tick) begin
               sh_q <= {serial_in_i, sh_q[8:1]};
               low_q <= low_q & ~serial_in_i;
               cnt_q <= ULSI_BIT_LAST;
               bit_q <= bit_q + 4'h1;
               if (bit_q == nbits - 4'h1)
                  st_q <= ULSI_RX_STOP;
            end
            ULSI_RX_STOP: if (tick) begin
               brk_o <= low_q & ~serial_in_i;
               frm_err_o <= ~serial_in_i & ~low_q;
               data_o <= (low_q & ~serial_in_i) ? 9'h000 :
                         (nbits == ULSI_DATA_LAST ? {1'b0, sh_q[8:1]} : sh_q);
               par_err_o <= par_en_i & ~nine_i & ~(low_q & ~serial_in_i) & ^sh_q;
               done_o <= 1'b1;
               // bad stop treated as next start, unless the whole frame was low (break state)
               st_q <= (low_q & ~serial_in_i) ? ULSI_RX_BRK :
                       (serial_in_i ? ULSI_RX_IDLE : ULSI_RX_START);
               cnt_q <= ULSI_HALF_LAST;
            end
            ULSI_RX_BRK: if (serial_in_i)
               st_q <= ULSI_RX_IDLE;
            default: st_q <= ULSI_RX_IDLE;
         endcase
      end
   end
endmodule

// >>> core/ulsi_wb.sv
`timescale 1ns/1ps
module ulsi_wb (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   output logic req_o
);
   // One access per request; ack lasts one cycle then drops
   assign req_o = cyc_i & stb_i & ~ack_o;
   always_ff @(posedge clk_i) begin
      if (rst_i)
         ack_o <= 1'b0;
      else
         ack_o <= req_o;
   end
endmodule

// >>> core/ulsi_core.sv
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module ulsi_core
   import ulsi_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic serial_in_i,
   input wire logic irq_select_pin_i,
   input wire logic bus_mode_b_i,
   input wire logic tx_fifo_empty_i,
   input wire logic tx_shift_empty_i,
   input wire logic tx_below_trig_i,
   input wire logic modem_event_i,
   input wire logic cts_rts_event_i,
   input wire logic xoff_match_i,
   input wire logic stop2_match_i,
   input wire logic [3:0] other_irq_i,
   input wire logic [8:0] spc0_i,
   input wire logic [8:0] spc1_i,
   input wire logic [8:0] spc2_i,
   input wire logic [8:0] spc3_i,
   output logic int_o,
   output logic int_oe_o,
   output logic irq_n_o,
   output logic irq_n_oe_o,
   output logic sleep_o,
   output logic rx_ready_o
);
   logic sin_m_q, sin_q;
   logic [7:0] ier_q, cfg_q;
   logic [ULSI_FIFO_W-1:0] mem_q [ULSI_FIFO_DEPTH];
   logic [ULSI_FIFO_AW:0] wp_q, rp_q;
   logic ovr_q, pe_q, fe_q, bi_q, de_q;
   logic the_q, spc_q, addr_q, ms_q, cr_q;
   logic [ULSI_TMO_W-1:0] tmo_q;
   logic [31:0] dat_q;
   logic tbt_q, head_new_q;
   logic isel_m_q, isel_q, modeb_m_q, modeb_q;
   logic req;
   logic rx_done;
   logic [8:0] rx_data;
   logic rx_pe, rx_fe, rx_bi;

   // Pin inputs pass two flops before any logic
   always_ff @(posedge clk_i) begin
      sin_m_q <= rst_i ? 1'b1 : serial_in_i;
      sin_q <= rst_i ? 1'b1 : sin_m_q;
      isel_m_q <= rst_i ? 1'b0 : irq_select_pin_i;
      isel_q <= rst_i ? 1'b0 : isel_m_q;
      modeb_m_q <= rst_i ? 1'b0 : bus_mode_b_i;
      modeb_q <= rst_i ? 1'b0 : modeb_m_q;
   end

   ulsi_wb u_wb (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i),
      .ack_o(ack_o),
      .req_o(req)
   );

   wire nine = cfg_q[ULSI_CF_NINE];
   wire enh = cfg_q[ULSI_CF_ENH];
   ulsi_rx u_rx (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .serial_in_i(sin_q),
      .nine_i(nine),
      .par_en_i(cfg_q[ULSI_CF_PAR]),
      .done_o(rx_done),
      .data_o(rx_data),
      .par_err_o(rx_pe),
      .frm_err_o(rx_fe),
      .brk_o(rx_bi)
   );

   // Bus decode
   wire [3:0] off = {adr_i[3:2], 2'b00};
   wire is_cfg = adr_i == ULSI_ADR_CFG;
   wire hit_dat = ~adr_i[4] & (off == ULSI_OFF_DATA);
   wire hit_ier = ~adr_i[4] & (off == ULSI_OFF_IER);
   wire hit_isr = ~adr_i[4] & (off == ULSI_OFF_ISR);
   wire hit_lsr = ~adr_i[4] & (off == ULSI_OFF_LSR);
   wire wr_b0 = req & we_i & sel_i[0];
   wire rd = req & ~we_i;
   wire rd_dat = rd & hit_dat;
   wire rd_lsr = rd & hit_lsr;
   wire rd_isr = rd & hit_isr;

   // Receive FIFO
   wire empty = wp_q == rp_q;
   wire full = (wp_q[ULSI_FIFO_AW] != rp_q[ULSI_FIFO_AW]) &&
               (wp_q[ULSI_FIFO_AW-1:0] == rp_q[ULSI_FIFO_AW-1:0]);
   wire push = rx_done & ~full;
   wire pop = rd_dat & ~empty;
   wire [ULSI_FIFO_W-1:0] head = mem_q[rp_q[ULSI_FIFO_AW-1:0]];
   wire [ULSI_FIFO_W-1:0] entry = {rx_bi, rx_fe, rx_pe, rx_data};
   wire entry_bad = rx_bi | rx_fe | (rx_pe & ~nine);

   always_ff @(posedge clk_i) begin
      if (push)
         mem_q[wp_q[ULSI_FIFO_AW-1:0]] <= entry;
      if (rst_i) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_q + (ULSI_FIFO_AW+1)'(push);
         rp_q <= rp_q + (ULSI_FIFO_AW+1)'(pop);
      end
   end

   // Head flags: the set wins over a same-cycle status read
   wire head_pe = ~empty & head[9] & ~nine;
   wire head_fe = ~empty & head[10];
   wire head_bi = ~empty & head[11];
   // Flags latch once, as an item arrives at the head
   // A level set would undo every status read while it waits
   wire [ULSI_FIFO_AW:0] level = wp_q - rp_q;
   wire head_next = (push & empty) |
                    (pop & (push | (level != (ULSI_FIFO_AW+1)'(1))));
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovr_q <= 1'b0;
         pe_q <= 1'b0;
         fe_q <= 1'b0;
         bi_q <= 1'b0;
         de_q <= 1'b0;
         head_new_q <= 1'b0;
      end else begin
         head_new_q <= head_next;
         ovr_q <= (rx_done & full) | (ovr_q & ~rd_lsr);
         pe_q <= (head_new_q & head_pe) | (pe_q & ~rd_lsr);
         fe_q <= (head_new_q & head_fe) | (fe_q & ~rd_lsr);
         bi_q <= (head_new_q & head_bi) | (bi_q & ~rd_lsr);
         de_q <= ~cfg_q[ULSI_CF_BYTE] & ((push & entry_bad) | (de_q & ~rd_lsr));
      end
   end

   wire [7:0] line_status = {de_q, tx_fifo_empty_i & tx_shift_empty_i, tx_fifo_empty_i, bi_q, fe_q,
                     nine ? (~empty & head[8]) : pe_q, ovr_q, ~empty};

   wire tmo_hit = tmo_q == ULSI_TMO_W'(ULSI_TMO_CYC);
   always_ff @(posedge clk_i) begin
      if (rst_i || empty || push || pop)
         tmo_q <= '0;
      else if (!tmo_hit)
         tmo_q <= tmo_q + 1'b1;
   end

   // Event flags: the set wins over the identification read, or the status read for addr_q
   wire spc_hit = nine & ((rx_data == spc0_i) | (rx_data == spc1_i) |
                  (rx_data == spc2_i) | (rx_data == spc3_i));
   wire [5:0] id_now;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         the_q <= 1'b0;
         spc_q <= 1'b0;
         addr_q <= 1'b0;
         ms_q <= 1'b0;
         cr_q <= 1'b0;
         tbt_q <= 1'b0;
      end else begin
         tbt_q <= tx_below_trig_i;
         // set on falling below trigger, cleared by ident read or refill
         the_q <= (tx_below_trig_i & ~tbt_q) |
                  (the_q & tx_below_trig_i & ~(rd_isr & (id_now == ULSI_ID_THE)));
         // special characters; match inputs are already event pulses
         spc_q <= (rx_done & spc_hit) | (~nine & (xoff_match_i | stop2_match_i)) |
                  (spc_q & ~(rd_isr & id_now == ULSI_ID_SPC));
         addr_q <= (push & nine & rx_data[8]) | (addr_q & ~rd_lsr);
         ms_q <= modem_event_i | (ms_q & ~rd_isr);
         cr_q <= cts_rts_event_i | (cr_q & ~(rd_isr & id_now == ULSI_ID_CR));
      end
   end

   wire rls_src = ier_q[ULSI_IE_RLS] & (ovr_q | pe_q | fe_q | bi_q | addr_q);
   // Timeout takes level 2 over once the waiting data has gone stale
   wire rda_src = ier_q[ULSI_IE_RDA] & ~empty & ~tmo_hit;
   wire tmo_src = ier_q[ULSI_IE_RDA] & tmo_hit & ~empty;
   wire the_src = ier_q[ULSI_IE_THE] & the_q;
   wire ms_src = ier_q[ULSI_IE_MS] & ms_q;
   // levels 5 and 6 enhanced only
   wire spc_src = enh & ier_q[ULSI_IE_SPC] & spc_q;
   wire cr_src = enh & cr_q & (~enh | ier_q[ULSI_IE_RTS] | ier_q[ULSI_IE_CTS]);

   assign id_now = rls_src ? ULSI_ID_RLS :
                   rda_src ? ULSI_ID_RDA :
                   tmo_src ? ULSI_ID_TMO :
                   the_src ? ULSI_ID_THE :
                   ms_src ? ULSI_ID_MS :
                   spc_src ? ULSI_ID_SPC :
                   cr_src ? ULSI_ID_CR : ULSI_ID_NONE;
   wire m650 = enh;
   wire bit5 = m650 ? id_now[5] : (cfg_q[ULSI_CF_M750] & cfg_q[ULSI_CF_F128]);
   wire [7:0] interrupt_identification = {2'b00, bit5, id_now[4:0]};
   wire pend = ~id_now[0];

   // Register writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ier_q <= ULSI_RST_IER;
         cfg_q <= ULSI_RST_CFG;
      end else begin
         if (wr_b0 && hit_ier)
            ier_q <= dat_i[7:0];
         if (wr_b0 && is_cfg)
            cfg_q <= dat_i[7:0];
      end
   end

   wire [7:0] rd_sel = hit_dat ? head[7:0] :
                       hit_ier ? ier_q :
                       hit_isr ? interrupt_identification :
                       hit_lsr ? line_status :
                       is_cfg ? cfg_q : 8'h00;

   wire slp = ier_q[ULSI_IE_SLP] | (cfg_q[ULSI_CF_M750] & ~enh & ~nine & ier_q[ULSI_IE_SPC]);
   wire oe_en = cfg_q[ULSI_CF_OUT2];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= '0;
         int_o <= 1'b0;
         int_oe_o <= 1'b0;
         irq_n_o <= 1'b1;
         irq_n_oe_o <= 1'b0;
         sleep_o <= 1'b0;
         rx_ready_o <= 1'b0;
      end else begin
         dat_q <= rd ? {24'h000000, rd_sel} : dat_q;
         int_o <= ~modeb_q & pend;
         int_oe_o <= ~modeb_q & (isel_q | oe_en);
         irq_n_o <= ~(modeb_q & ((pend & oe_en) | (|other_irq_i)));
         irq_n_oe_o <= modeb_q;
         sleep_o <= slp;
         rx_ready_o <= ~empty;
      end
   end
   assign dat_o = dat_q;
endmodule

// >>> tb/ulsi_host.sv
`timescale 1ns/1ps
module ulsi_host (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [4:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 5'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   // Request held until ack seen at an edge or 1000 cycles pass; no ack latency assumed
   task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d,
                       output logic [31:0] q, output bit late);
      int n;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= 4'h1;
      dat_o <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 1000);
      q = dat_i;
      late = (ack_i !== 1'b1);
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
   endtask
endmodule

// >>> tb/ulsi_core_properties.sv
`timescale 1ns/1ps
module ulsi_core_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic irq_select_pin_i,
   input wire logic bus_mode_b_i,
   input wire logic tx_fifo_empty_i,
   input wire logic tx_shift_empty_i,
   input wire logic [3:0] other_irq_i,
   input wire logic int_o,
   input wire logic int_oe_o,
   input wire logic irq_n_o,
   input wire logic irq_n_oe_o
);
   wire rd_lsr = ack_o && !we_i && adr_i == 5'h0C;
   property p_ack;
      @(posedge clk_i) disable iff (rst_i) cyc_i && stb_i && !ack_o |=> ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_te;
      @(posedge clk_i) disable iff (rst_i) rd_lsr |-> dat_o[5] == $past(tx_fifo_empty_i);
   endproperty
   a_te: assert property (p_te) else $error("fifo empty bit wrong");
   property p_ti;
      @(posedge clk_i) disable iff (rst_i)
         rd_lsr |-> dat_o[6] == $past(tx_fifo_empty_i && tx_shift_empty_i);
   endproperty
   a_ti: assert property (p_ti) else $error("idle bit wrong");
   property p_lsr_wide;
      @(posedge clk_i) disable iff (rst_i) rd_lsr |-> dat_o[31:8] == 24'h0;
   endproperty
   a_lsr_wide: assert property (p_lsr_wide) else $error("upper read bits set");
   property p_unmapped;
      @(posedge clk_i) disable iff (rst_i) ack_o && !we_i && adr_i == 5'h14 |-> dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_pin_sel;
      @(posedge clk_i) disable iff (rst_i)
         (!bus_mode_b_i && irq_select_pin_i)[*4] |-> int_oe_o;
   endproperty
   a_pin_sel: assert property (p_pin_sel) else $error("pin not driven");
   property p_shared_or;
      @(posedge clk_i) disable iff (rst_i)
         (bus_mode_b_i && other_irq_i != 4'h0)[*4] |-> !irq_n_o;
   endproperty
   a_shared_or: assert property (p_shared_or) else $error("shared request idle");
   property p_rst;
      @(posedge clk_i) rst_i |=> !ack_o && !int_oe_o && irq_n_o && !irq_n_oe_o;
   endproperty
   a_rst: assert property (p_rst) else $error("reset outputs wrong");
   c_read: cover property (@(posedge clk_i) rd_lsr);
   c_int: cover property (@(posedge clk_i) $rose(int_o));
   c_irq: cover property (@(posedge clk_i) $fell(irq_n_o));
endmodule
bind ulsi_core ulsi_core_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
   .irq_select_pin_i(irq_select_pin_i), .bus_mode_b_i(bus_mode_b_i),
   .tx_fifo_empty_i(tx_fifo_empty_i), .tx_shift_empty_i(tx_shift_empty_i),
   .other_irq_i(other_irq_i), .int_o(int_o), .int_oe_o(int_oe_o), .irq_n_o(irq_n_o),
   .irq_n_oe_o(irq_n_oe_o));

// >>> tb/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
   $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module tb
   import ulsi_pkg::*;
;
   localparam logic [4:0] A_DAT = 5'h00, A_IER = 5'h04, A_ISR = 5'h08, A_LSR = 5'h0C;
   logic clk_i = 1'b0, rst_i = 1'b1, ser = 1'b1, sel_pin = 1'b0, mode_b = 1'b0;
   logic tfe = 1'b1, tse = 1'b1, tbt = 1'b0;
   logic [3:0] ev = 4'h0, oth = 4'h0;
   logic cyc, stb, we, ack, int_o, int_oe, irq_n, irq_n_oe, slp, rdy;
   logic [4:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q;
   int num_errors = 0, cmp_count = 0;
   always #10 clk_i = ~clk_i;
   ulsi_host u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   ulsi_core u_ulsi_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .serial_in_i(ser),
      .irq_select_pin_i(sel_pin), .bus_mode_b_i(mode_b), .tx_fifo_empty_i(tfe),
      .tx_shift_empty_i(tse), .tx_below_trig_i(tbt), .modem_event_i(ev[0]),
      .cts_rts_event_i(ev[1]), .xoff_match_i(ev[2]), .stop2_match_i(ev[3]),
      .other_irq_i(oth), .spc0_i(9'h1FF), .spc1_i(9'h1FF), .spc2_i(9'h1FF), .spc3_i(9'h1FF),
      .int_o(int_o), .int_oe_o(int_oe), .irq_n_o(irq_n), .irq_n_oe_o(irq_n_oe),
      .sleep_o(slp), .rx_ready_o(rdy));
   // A bus wait that runs out ends the run as a failure
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      bit late;
      u_host.xfer(w, a, d, q, late);
      if (late) begin
         num_errors++;
         summarize();
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
      repeat (3) @(posedge clk_i);
   endtask
   task automatic rd(input logic [4:0] a);
      bus(1'b0, a, 8'h00);
   endtask
   task automatic pulse(input logic [3:0] m);
      @(posedge clk_i);
      ev <= m;
      @(posedge clk_i);
      ev <= 4'h0;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic bits(input int n);
      repeat (n * ULSI_BIT_CYC) @(posedge clk_i);
   endtask
   // Low for whole frame and beyond, then back high
   task automatic brk();
      ser <= 1'b0;
      bits(12);
      ser <= 1'b1;
      bits(2);
   endtask
   // Start bit, n data bits LSB first, stop bit, short idle
   task automatic frame(input logic [8:0] b, input int n);
      ser <= 1'b0;
      bits(1);
      for (int i = 0; i < n; i++) begin
         ser <= b[i];
         bits(1);
      end
      ser <= 1'b1;
      bits(2);
   endtask
   task automatic t_reset();
      rd(A_IER); `CHK(q[7:0], ULSI_RST_IER)
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_NONE)
      rd(A_LSR); `CHK(q[0], 1'b0)
      rd(5'h14); `CHK(q, 32'h0)
   endtask
   task automatic t_tx();
      tfe <= 1'b1; tse <= 1'b0; tbt <= 1'b1;
      wr(A_IER, 8'h02);
      rd(A_LSR); `CHK(q[6:5], 2'b01)
      `CHK(int_o, 1'b1)
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_THE)
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_NONE)
      tse <= 1'b1;
      wr(A_IER, 8'h00);
      rd(A_LSR); `CHK(q[6:5], 2'b11)
   endtask
   task automatic t_rx(input logic [7:0] b);
      wr(A_IER, 8'h01);
      frame({1'b0, b}, 8);
      rd(A_LSR); `CHK(q[0], 1'b1)
      `CHK(rdy, 1'b1)
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_RDA)
      // Past four character periods with nothing read or received
      bits(41);
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_TMO)
      rd(A_DAT); `CHK(q[7:0], b)
      rd(A_LSR); `CHK(q[0], 1'b0)
   endtask
   task automatic t_brk();
      wr(A_IER, 8'h04);
      brk();
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_RLS)
      rd(A_LSR); `CHK({q[7], q[4]}, 2'b11)
      rd(A_LSR); `CHK({q[7], q[4]}, 2'b00)
      rd(A_DAT); `CHK(q[7:0], 8'h00)
      rd(A_LSR); `CHK(q[0], 1'b0)
      wr(ULSI_ADR_CFG, 8'h04);
      brk();
      rd(A_LSR); `CHK({q[7], q[4]}, 2'b01)
      rd(A_DAT);
      wr(ULSI_ADR_CFG, 8'h00);
   endtask
   task automatic t_prio();
      wr(ULSI_ADR_CFG, 8'h02);
      wr(A_IER, 8'hA8);
      pulse(4'h2);
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_CR)
      pulse(4'h2);
      pulse(4'h4);
      pulse(4'h1);
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_MS)
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_SPC)
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_CR)
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_NONE)
      wr(ULSI_ADR_CFG, 8'h00);
      wr(A_IER, 8'hC0);
      pulse(4'h2);
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_NONE)
   endtask
   task automatic t_sleep();
      wr(A_IER, 8'h10); `CHK(slp, 1'b1)
      wr(A_IER, 8'h00); `CHK(slp, 1'b0)
      wr(ULSI_ADR_CFG, 8'h18);
      wr(A_IER, 8'h20); `CHK(slp, 1'b1)
      rd(A_ISR); `CHK(q[5:0], 6'h21)
      wr(ULSI_ADR_CFG, 8'h08);
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_NONE)
      wr(A_IER, 8'h00);
      wr(ULSI_ADR_CFG, 8'h00);
   endtask
   task automatic t_pins();
      wr(A_IER, 8'h08);
      pulse(4'h1); `CHK(int_o, 1'b1)
      sel_pin <= 1'b1;
      wr(ULSI_ADR_CFG, 8'h00); `CHK(int_oe, 1'b1)
      sel_pin <= 1'b0;
      wr(ULSI_ADR_CFG, 8'h00); `CHK(int_oe, 1'b0)
      wr(ULSI_ADR_CFG, 8'h20); `CHK(int_oe, 1'b1)
      mode_b <= 1'b1;
      sel_pin <= 1'b1;
      wr(ULSI_ADR_CFG, 8'h20); `CHK(irq_n, 1'b0)
      `CHK(irq_n_oe, 1'b1)
      `CHK(int_oe, 1'b0)
      wr(ULSI_ADR_CFG, 8'h00); `CHK(irq_n, 1'b1)
      oth <= 4'h2;
      wr(ULSI_ADR_CFG, 8'h00); `CHK(irq_n, 1'b0)
      rd(A_ISR);
   endtask
   task automatic t_nine();
      wr(ULSI_ADR_CFG, 8'h03);
      wr(A_IER, 8'h24);
      // Address bit set and a match with the special value
      frame(9'h1FF, 9);
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_RLS)
      rd(A_LSR); `CHK({q[7], q[2]}, 2'b01)
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_SPC)
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_NONE)
      rd(A_DAT); `CHK(q[7:0], 8'hFF)
      rd(A_LSR); `CHK(q[2], 1'b0)
      wr(A_IER, 8'h00);
      wr(ULSI_ADR_CFG, 8'h00);
   endtask
   task automatic t_par();
      wr(ULSI_ADR_CFG, 8'h80);
      wr(A_IER, 8'h04);
      // Data 01 with parity bit 0: odd count, bad parity
      frame(9'h001, 9);
      rd(A_ISR); `CHK(q[5:0], ULSI_ID_RLS)
      rd(A_LSR); `CHK({q[7], q[2]}, 2'b11)
      rd(A_LSR); `CHK({q[7], q[2]}, 2'b00)
      rd(A_DAT); `CHK(q[7:0], 8'h01)
      wr(A_IER, 8'h00);
      wr(ULSI_ADR_CFG, 8'h00);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_tx();
      t_rx(8'hA5);
      t_brk();
      t_nine();
      t_par();
      t_prio();
      t_sleep();
      t_pins();
      summarize();
   end
   // About 50k cycles expected; 80k means a hang
   initial begin
      #1_600_000;
      num_errors++;
      summarize();
   end
endmodule
